// ===== hdl/ssr_status_unit.sv
`timescale 1ns/1ps
module ssr_status_unit (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Command strobes and write data
    input wire ssr_pkg::ssr_cmds_t cmd,
    input wire logic [7:0] wr_data,
    // Event sources
    input wire ssr_pkg::ssr_events_t evt,
    input wire logic [7:0] error_set,
    input wire logic [7:0] device_event_set,
    input wire logic unrecoverable_error,
    input wire logic queue_not_empty,
    input wire logic serial_link_mode,
    // Register views
    output logic [7:0] status_summary_byte,
    output logic [7:0] poll_byte,
    output logic [7:0] standard_event_flags,
    output logic [7:0] request_enable_mask,
    output logic [7:0] standard_event_enable,
    output logic [7:0] device_event_flags,
    output logic [7:0] error_flags,
    // Bus side
    output logic service_request,
    output logic queue_flush
);
    logic [7:0] evt_flags_reg;
    logic [7:0] evt_flags_next;
    logic [7:0] req_mask_reg;
    logic [7:0] evt_mask_reg;
    logic [7:0] dev_mask_reg;
    logic [7:0] dev_flags_reg;
    logic [7:0] dev_flags_next;
    logic [7:0] err_reg;
    logic [7:0] err_next;
    logic req_svc_reg;
    logic req_svc_next;
    logic [7:0] sum_view_reg;
    logic [7:0] poll_view_reg;
    logic srq_reg;
    logic flush_reg;
    logic master_prev_reg;
    logic pon_pending_reg;

    wire logic [7:0] evt_set;
    wire logic [7:0] sum_raw;
    wire logic [7:0] sum_full;
    wire logic [7:0] poll_full;
    wire logic [7:0] master_word;
    wire logic [7:0] req_word;
    wire logic evt_sum;
    wire logic dev_sum;
    wire logic msg_avail;
    wire logic master_sum;
    wire logic master_rise;
    wire logic clr_evt;
    wire logic clr_dev;
    wire logic clr_err;

    // Error set strobes, not the error register, feed flags directly, no mask
    assign evt_set[ssr_pkg::EVT_CMD_BIT] = evt.cmd_err |
        error_set[ssr_pkg::ERR_HEADER_BIT] |
        error_set[ssr_pkg::ERR_FORMAT_BIT] |
        error_set[ssr_pkg::ERR_LENGTH_BIT];
    assign evt_set[ssr_pkg::EVT_EXEC_BIT] = evt.exe_err |
        error_set[ssr_pkg::ERR_RANGE_BIT] |
        error_set[ssr_pkg::ERR_NOEXEC_BIT];
    assign evt_set[ssr_pkg::EVT_DEV_BIT] = evt.dev_err |
        error_set[ssr_pkg::ERR_LINK_BIT] |
        error_set[ssr_pkg::ERR_BACKUP_BIT];
    assign evt_set[ssr_pkg::EVT_QUERY_BIT] = evt.qry_err;
    assign evt_set[ssr_pkg::EVT_DONE_BIT] = evt.op_done;
    // Pending bit covers power-up, since reset itself must clear the flags
    assign evt_set[ssr_pkg::EVT_POWER_BIT] = evt.power_up |
        pon_pending_reg;
    assign evt_set[ssr_pkg::EVT_SPARE_HI] = 1'b0;
    assign evt_set[ssr_pkg::EVT_SPARE_LO] = 1'b0;

    assign clr_evt = cmd.clear_status | cmd.read_event_flags;
    assign clr_dev = cmd.clear_status;
    assign clr_err = cmd.clear_status | cmd.read_error_reg;

    // Set wins over a clear in the same cycle, so no event is lost
    for (genvar i = 0; i < 8; i++) begin : g_flag
        assign evt_flags_next[i] = ((evt_flags_reg[i] & ~clr_evt) |
            evt_set[i]) & ssr_pkg::EVT_USED[i];
        assign dev_flags_next[i] = (dev_flags_reg[i] & ~clr_dev) |
            device_event_set[i];
        assign err_next[i] = (err_reg[i] & ~clr_err) | error_set[i];
    end

    assign evt_sum = |(evt_flags_reg & evt_mask_reg);
    assign dev_sum = |(dev_flags_reg & dev_mask_reg);
    assign msg_avail = queue_not_empty & ~serial_link_mode;
    assign sum_raw[ssr_pkg::SUM_FAULT_BIT] = unrecoverable_error;
    assign sum_raw[ssr_pkg::SUM_MASTER_BIT] = 1'b0;
    assign sum_raw[ssr_pkg::SUM_EVENT_BIT] = evt_sum;
    assign sum_raw[ssr_pkg::SUM_MSG_BIT] = msg_avail;
    assign sum_raw[ssr_pkg::SUM_DEVICE_BIT] = dev_sum;
    assign sum_raw[ssr_pkg::SUM_SPARE_MSB:0] = ssr_pkg::ZERO3;
    assign master_sum = |(sum_raw & req_mask_reg);
    assign master_rise = master_sum & ~master_prev_reg;
    // Poll read clears the flag; a new rise in that cycle still wins
    assign req_svc_next = master_rise |
        (req_svc_reg & ~cmd.serial_poll & master_sum);
    assign master_word = {7'h00, master_sum} << ssr_pkg::SUM_MASTER_BIT;
    assign req_word = {7'h00, req_svc_next} << ssr_pkg::SUM_MASTER_BIT;
    assign sum_full = sum_raw | master_word;
    assign poll_full = sum_raw | req_word;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            evt_flags_reg <= ssr_pkg::ZERO8;
            dev_flags_reg <= ssr_pkg::ZERO8;
            err_reg <= ssr_pkg::ZERO8;
            req_mask_reg <= ssr_pkg::ZERO8;
            evt_mask_reg <= ssr_pkg::ZERO8;
            dev_mask_reg <= ssr_pkg::ZERO8;
            req_svc_reg <= 1'b0;
            master_prev_reg <= 1'b0;
            pon_pending_reg <= 1'b1;
        end else begin
            evt_flags_reg <= evt_flags_next;
            dev_flags_reg <= dev_flags_next;
            err_reg <= err_next;
            req_svc_reg <= req_svc_next;
            master_prev_reg <= master_sum;
            pon_pending_reg <= 1'b0;
            if (cmd.wr_req_enable) begin
                req_mask_reg <= wr_data & ssr_pkg::REQ_MASK_USED;
            end
            if (cmd.wr_evt_enable) begin
                evt_mask_reg <= wr_data;
            end
            if (cmd.wr_dev_enable) begin
                dev_mask_reg <= wr_data;
            end
        end
    end

    // Query view carries the master summary, poll view the request flag
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sum_view_reg <= ssr_pkg::ZERO8;
            poll_view_reg <= ssr_pkg::ZERO8;
            srq_reg <= 1'b0;
            flush_reg <= 1'b0;
        end else begin
            sum_view_reg <= sum_full;
            poll_view_reg <= poll_full;
            srq_reg <= req_svc_next;
            flush_reg <= evt.qry_err;
        end
    end

    assign status_summary_byte = sum_view_reg;
    assign poll_byte = poll_view_reg;
    assign standard_event_flags = evt_flags_reg;
    assign request_enable_mask = req_mask_reg;
    assign standard_event_enable = evt_mask_reg;
    assign device_event_flags = dev_flags_reg;
    assign error_flags = err_reg;
    assign service_request = srq_reg;
    assign queue_flush = flush_reg;

    property p_pon_after_reset;
        @(posedge clk_sys) $fell(srst) |=>
            evt_flags_reg[ssr_pkg::EVT_POWER_BIT];
    endproperty
    a_pon_after_reset: assert property (p_pon_after_reset)
        else $error("power-on flag not set after reset");

    property p_clear_flags;
        @(posedge clk_sys) disable iff (srst)
        (clr_evt && evt_set == ssr_pkg::ZERO8) |=>
            evt_flags_reg == ssr_pkg::ZERO8;
    endproperty
    a_clear_flags: assert property (p_clear_flags)
        else $error("standard event flags not cleared");

    property p_cmd_flag_set;
        @(posedge clk_sys) disable iff (srst)
        evt.cmd_err |=> evt_flags_reg[ssr_pkg::EVT_CMD_BIT];
    endproperty
    a_cmd_flag_set: assert property (p_cmd_flag_set)
        else $error("command error flag not set");

    property p_query_flush;
        @(posedge clk_sys) disable iff (srst)
        evt.qry_err |=> queue_flush && evt_flags_reg[ssr_pkg::EVT_QUERY_BIT];
    endproperty
    a_query_flush: assert property (p_query_flush)
        else $error("query error without flush");

    property p_event_sum;
        @(posedge clk_sys) disable iff (srst)
        ##1 status_summary_byte[ssr_pkg::SUM_EVENT_BIT] ==
            $past(|(evt_flags_reg & evt_mask_reg));
    endproperty
    a_event_sum: assert property (p_event_sum)
        else $error("event summary bit wrong");

    property p_msg_serial;
        @(posedge clk_sys) disable iff (srst)
        ##1 $past(serial_link_mode) |->
            !status_summary_byte[ssr_pkg::SUM_MSG_BIT];
    endproperty
    a_msg_serial: assert property (p_msg_serial)
        else $error("message available set on serial link");

    property p_srq_rise;
        @(posedge clk_sys) disable iff (srst)
        master_rise |=> service_request &&
            poll_byte[ssr_pkg::SUM_MASTER_BIT];
    endproperty
    a_srq_rise: assert property (p_srq_rise)
        else $error("no service request on enabled rise");

    property p_poll_clear;
        @(posedge clk_sys) disable iff (srst)
        (cmd.serial_poll && !master_rise) |=> !service_request;
    endproperty
    a_poll_clear: assert property (p_poll_clear)
        else $error("request flag not cleared by poll");

    property p_reserved;
        @(posedge clk_sys) disable iff (srst)
        status_summary_byte[ssr_pkg::SUM_SPARE_MSB:0] == ssr_pkg::ZERO3 &&
            !evt_flags_reg[ssr_pkg::EVT_SPARE_HI] &&
            !evt_flags_reg[ssr_pkg::EVT_SPARE_LO];
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bits not zero");

    property p_exec_set;
        @(posedge clk_sys) disable iff (srst)
        evt.exe_err |=> evt_flags_reg[ssr_pkg::EVT_EXEC_BIT];
    endproperty
    a_exec_set: assert property (p_exec_set)
        else $error("execution error flag not set");

    property p_dev_err_set;
        @(posedge clk_sys) disable iff (srst)
        evt.dev_err |=> evt_flags_reg[ssr_pkg::EVT_DEV_BIT];
    endproperty
    a_dev_err_set: assert property (p_dev_err_set)
        else $error("device error flag not set");

    property p_done_set;
        @(posedge clk_sys) disable iff (srst)
        evt.op_done |=> evt_flags_reg[ssr_pkg::EVT_DONE_BIT];
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("operation complete flag not set");

    property p_fold_length;
        @(posedge clk_sys) disable iff (srst)
        error_set[ssr_pkg::ERR_LENGTH_BIT] |=>
            evt_flags_reg[ssr_pkg::EVT_CMD_BIT];
    endproperty
    a_fold_length: assert property (p_fold_length)
        else $error("length error not folded");

    property p_fold_range;
        @(posedge clk_sys) disable iff (srst)
        error_set[ssr_pkg::ERR_RANGE_BIT] |=>
            evt_flags_reg[ssr_pkg::EVT_EXEC_BIT];
    endproperty
    a_fold_range: assert property (p_fold_range)
        else $error("range error not folded");

    property p_fold_link;
        @(posedge clk_sys) disable iff (srst)
        error_set[ssr_pkg::ERR_LINK_BIT] |=>
            evt_flags_reg[ssr_pkg::EVT_DEV_BIT];
    endproperty
    a_fold_link: assert property (p_fold_link)
        else $error("link error not folded");

    property p_dev_sum;
        @(posedge clk_sys) disable iff (srst)
        ##1 status_summary_byte[ssr_pkg::SUM_DEVICE_BIT] ==
            $past(|(dev_flags_reg & dev_mask_reg));
    endproperty
    a_dev_sum: assert property (p_dev_sum)
        else $error("device summary bit wrong");

    property p_msg_avail;
        @(posedge clk_sys) disable iff (srst)
        ##1 status_summary_byte[ssr_pkg::SUM_MSG_BIT] ==
            $past(queue_not_empty && !serial_link_mode);
    endproperty
    a_msg_avail: assert property (p_msg_avail)
        else $error("message available bit wrong");

    property p_fault_bit;
        @(posedge clk_sys) disable iff (srst)
        ##1 status_summary_byte[ssr_pkg::SUM_FAULT_BIT] ==
            $past(unrecoverable_error);
    endproperty
    a_fault_bit: assert property (p_fault_bit)
        else $error("fault bit wrong");

    property p_mask_refused;
        @(posedge clk_sys) disable iff (srst)
        (request_enable_mask & ~ssr_pkg::REQ_MASK_USED) == ssr_pkg::ZERO8;
    endproperty
    a_mask_refused: assert property (p_mask_refused)
        else $error("refused request mask bit set");

    property p_srq_view;
        @(posedge clk_sys) disable iff (srst)
        service_request == poll_byte[ssr_pkg::SUM_MASTER_BIT];
    endproperty
    a_srq_view: assert property (p_srq_view)
        else $error("poll view and service request differ");

    property p_err_clear;
        @(posedge clk_sys) disable iff (srst)
        (cmd.read_error_reg && error_set == ssr_pkg::ZERO8) |=>
            error_flags == ssr_pkg::ZERO8;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("error register not cleared by its query");

    property p_master_hold;
        @(posedge clk_sys) disable iff (srst)
        (master_sum && !cmd.clear_status && !clr_evt && !clr_dev &&
            $stable(req_mask_reg) && $stable(evt_mask_reg)) |=>
            master_sum;
    endproperty
    a_master_hold: assert property (p_master_hold)
        else $error("master summary dropped without a clear");
endmodule

// ===== hdl/ssr_pkg.sv
// What this block does
// - Eight-bit summary byte returned to the controller on each serial poll.
// - Bit 6 master summary set while any enabled summary bit is set.
// - Master summary rising sets request flag, raises service request.
// - Request flag follows the pending request, cleared when polled.
// - Master summary shown only by status query, held until events clear.
// - Bit 5 is OR of event flags left unmasked by their enable.
// - Bit 4 set while a response message waits in the output queue.
// - Bit 3 is OR of device event flags left unmasked by their enable.
// - On the serial link the message-available bit is never set.
// - Each request enable bit at one admits its summary bit.
// - Event flags cleared by clear-status, by their query, at power-on.
// - Bit 7 power-on flag set at power-up and on outage recovery.
// - Bit 5 set on header, count, format or unsupported-command errors.
// - Bit 4 set when a command cannot execute: range, unsettable, blocked.
// - Bit 3 set when an internal anomaly prevents executing a command.
// - Bit 2 set and output queue flushed on empty read, overflow, loss.
// - Bit 0 set once all messages before operation-complete finish.
// - Each event flag counts in the summary only when enabled.
// - Device summary bit raised when any enabled device event flag is one.
// - Error bits fold, unmasked, into command, execution and device flags.
package ssr_pkg;
    localparam int SUM_FAULT_BIT = 7;
    localparam int SUM_MASTER_BIT = 6;
    localparam int SUM_EVENT_BIT = 5;
    localparam int SUM_MSG_BIT = 4;
    localparam int SUM_DEVICE_BIT = 3;
    localparam int SUM_SPARE_MSB = 2;
    localparam int EVT_POWER_BIT = 7;
    localparam int EVT_SPARE_HI = 6;
    localparam int EVT_CMD_BIT = 5;
    localparam int EVT_EXEC_BIT = 4;
    localparam int EVT_DEV_BIT = 3;
    localparam int EVT_QUERY_BIT = 2;
    localparam int EVT_SPARE_LO = 1;
    localparam int EVT_DONE_BIT = 0;
    // Error register bit positions
    localparam int ERR_LENGTH_BIT = 6;
    localparam int ERR_HEADER_BIT = 5;
    localparam int ERR_FORMAT_BIT = 4;
    localparam int ERR_RANGE_BIT = 3;
    localparam int ERR_NOEXEC_BIT = 2;
    localparam int ERR_LINK_BIT = 1;
    localparam int ERR_BACKUP_BIT = 0;
    localparam logic [7:0] SUM_USED = 8'hf8;
    localparam logic [7:0] REQ_MASK_USED = 8'hb8;
    localparam logic [7:0] EVT_USED = 8'hbd;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [2:0] ZERO3 = 3'h0;

    // Hardware event strobes, one cycle each
    typedef struct packed {
        logic cmd_err;
        logic exe_err;
        logic dev_err;
        logic qry_err;
        logic op_done;
        logic power_up;
    } ssr_events_t;

    // Command strobes from the message parser
    typedef struct packed {
        logic clear_status;
        logic read_event_flags;
        logic read_error_reg;
        logic serial_poll;
        logic wr_req_enable;
        logic wr_evt_enable;
        logic wr_dev_enable;
    } ssr_cmds_t;
endpackage

// ===== test/ssr_ctrl_model.sv
`timescale 1ns/1ps
module ssr_ctrl_model #(
    parameter int DELAY = 3
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Device side
    input wire logic en,
    input wire logic service_request,
    input wire logic [7:0] poll_byte,
    output logic poll,
    output logic [7:0] last_poll
);
    int wait_cnt;
    // Slow host: polls only after the request has stood DELAY+1 cycles
    always_ff @(posedge clk_sys) begin
        if (srst || !en || !service_request || poll) begin
            wait_cnt <= 0;
            poll <= 1'b0;
        end else if (wait_cnt == DELAY) begin
            poll <= 1'b1;
            last_poll <= poll_byte;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end
endmodule

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    ssr_pkg::ssr_cmds_t cmd = '0;
    ssr_pkg::ssr_cmds_t cmd_dut;
    ssr_pkg::ssr_events_t evt = '0;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] err_set = 8'h00;
    logic [7:0] dev_set = 8'h00;
    logic unrec = 1'b0;
    logic qne = 1'b0;
    logic serial = 1'b0;
    logic en = 1'b0;
    logic qf_seen = 1'b0;
    logic poll, srq, qflush;
    logic [7:0] sum_view, pb, sef, rem, see, def, erf, lp;
    logic [5:0] ev_tab [6] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
    logic [7:0] ev_exp [6] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h01, 8'h80};
    logic [7:0] er_tab [3] = '{8'h40, 8'h08, 8'h02};
    logic [7:0] er_exp [3] = '{8'h20, 8'h10, 8'h08};
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;

    initial forever #20 clk_sys = ~clk_sys;

    // The host's poll merges into the command strobes
    always_comb begin
        cmd_dut = cmd;
        cmd_dut.serial_poll = cmd.serial_poll | poll;
    end

    ssr_status_unit dut (.clk_sys(clk_sys), .srst(srst), .cmd(cmd_dut),
        .wr_data(wr_data), .evt(evt), .error_set(err_set),
        .device_event_set(dev_set), .unrecoverable_error(unrec),
        .queue_not_empty(qne), .serial_link_mode(serial),
        .status_summary_byte(sum_view), .poll_byte(pb),
        .standard_event_flags(sef), .request_enable_mask(rem),
        .standard_event_enable(see), .device_event_flags(def),
        .error_flags(erf), .service_request(srq), .queue_flush(qflush));

    ssr_ctrl_model model (.clk_sys(clk_sys), .srst(srst), .en(en),
        .service_request(srq), .poll_byte(pb), .poll(poll),
        .last_poll(lp));

    // Sampled mid-cycle so the one-cycle flush pulse is seen settled
    always @(negedge clk_sys) begin
        if (qflush === 1'b1) qf_seen = 1'b1;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            final_report();
        end
    end

    task final_report;
        $display("n_fail=%0d compares=%0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            n_fail++;
        end
    endtask

    task cmd_go(input logic [6:0] c, input logic [7:0] d);
        @(negedge clk_sys);
        cmd = c;
        wr_data = d;
        @(negedge clk_sys);
        cmd = '0;
        repeat (2) @(negedge clk_sys);
    endtask

    task evt_go(input logic [5:0] e, input logic [7:0] r, input logic [7:0] v);
        @(negedge clk_sys);
        evt = e;
        err_set = r;
        dev_set = v;
        @(negedge clk_sys);
        evt = '0;
        err_set = 8'h00;
        dev_set = 8'h00;
        repeat (2) @(negedge clk_sys);
    endtask

    initial begin
        repeat (20) @(negedge clk_sys);
        srst = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk("sef", 8'h80, sef);
        chk("masks", 8'h00, rem | see);
        cmd_go(7'h20, 8'h00);
        chk("sef", 8'h00, sef);
        for (int i = 0; i < 6; i++) begin
            evt_go(ev_tab[i], 8'h00, 8'h00);
            chk("sef", ev_exp[i], sef);
            cmd_go(7'h20, 8'h00);
        end
        chk("qflush", 8'h01, {7'h00, qf_seen});
        for (int i = 0; i < 3; i++) begin
            evt_go(6'h00, er_tab[i], 8'h00);
            chk("sef", er_exp[i], sef);
            chk("erf", er_tab[i], erf);
            cmd_go(7'h30, 8'h00);
            chk("erf", 8'h00, erf);
        end
        cmd_go(7'h02, 8'h20);
        chk("see", 8'h20, see);
        cmd_go(7'h04, 8'h20);
        evt_go(6'h20, 8'h00, 8'h00);
        chk("sum", 8'h60, sum_view);
        chk("pb", 8'h60, pb);
        chk("srq", 8'h01, {7'h00, srq});
        en = 1'b1;
        for (int k = 0; k < 20 && srq === 1'b1; k++) @(negedge clk_sys);
        en = 1'b0;
        chk("srq", 8'h00, {7'h00, srq});
        chk("pb", 8'h20, pb);
        chk("lp", 8'h60, lp);
        chk("sum", 8'h60, sum_view);
        cmd_go(7'h40, 8'h00);
        chk("sum", 8'h00, sum_view);
        cmd_go(7'h04, 8'h00);
        evt_go(6'h20, 8'h00, 8'h00);
        chk("sum", 8'h20, sum_view);
        chk("srq", 8'h00, {7'h00, srq});
        cmd_go(7'h02, 8'h00);
        chk("sum", 8'h00, sum_view);
        cmd_go(7'h41, 8'h08);
        evt_go(6'h00, 8'h00, 8'h08);
        chk("def", 8'h08, def);
        chk("sum", 8'h08, sum_view);
        cmd_go(7'h40, 8'h00);
        qne = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk("sum", 8'h10, sum_view);
        serial = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk("sum", 8'h00, sum_view);
        qne = 1'b0;
        unrec = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk("sum", 8'h80, sum_view);
        unrec = 1'b0;
        cmd_go(7'h04, 8'hff);
        chk("rem", 8'hb8, rem);
        final_report();
    end
endmodule
